// ---- hdl/xsw_pkg.sv ----
// Shared constants and lane helpers for the serial memory write link
package xsw_pkg;
    localparam logic [7:0] OP_FAST_WR = 8'hDA;
    localparam logic [7:0] OP_DDR_FAST_WR = 8'hDD;
    localparam logic [7:0] OP_DUAL_DATA_WR = 8'hA2;
    localparam logic [7:0] OP_DUAL_ADDR_DATA_WR = 8'hA1;
    localparam logic [7:0] OP_QUAD_DATA_WR = 8'h32;
    localparam logic [7:0] OP_QUAD_ADDR_DATA_WR = 8'hD2;
    localparam logic [7:0] MODE_DDR_XIP = 8'hA5;
    localparam logic [3:0] MODE_XIP_NIBBLE = 4'hA;
    localparam int ADDR_W = 18;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;
    localparam logic [5:0] OPC_BITS = 6'h08;
    localparam logic [5:0] HDR_BITS = 6'h20;
    localparam logic [5:0] BYTE_BITS = 6'h08;
    localparam logic [39:0] SHIFT_RESET = 40'h0000000000;
    localparam int WR_EN_BIT = 1;
    localparam int SYS_PERIOD_NS = 4;
    localparam int SCK_PERIOD_NS = 64;
    localparam logic [7:0] SCK_HALF_CYC =
        8'(SCK_PERIOD_NS / (2 * SYS_PERIOD_NS));
    localparam logic [7:0] SCK_EMIT_AT = 8'(SCK_HALF_CYC / 2);

    function automatic logic is_write_op(input logic [7:0] op);
        return op inside {OP_FAST_WR, OP_DDR_FAST_WR, OP_DUAL_DATA_WR,
            OP_DUAL_ADDR_DATA_WR, OP_QUAD_DATA_WR, OP_QUAD_ADDR_DATA_WR};
    endfunction

    function automatic logic is_ddr(input logic [7:0] op);
        return op == OP_DDR_FAST_WR;
    endfunction

    // Lanes used after the opcode; data_sec picks data over header
    function automatic logic [3:0] lanes_of(input logic [7:0] op,
                                            input logic data_sec);
        logic [3:0] n;
        n = 4'h1;
        case (op)
            OP_DDR_FAST_WR: n = 4'h4;
            OP_DUAL_DATA_WR: n = data_sec ? 4'h2 : 4'h1;
            OP_DUAL_ADDR_DATA_WR: n = 4'h2;
            OP_QUAD_DATA_WR: n = data_sec ? 4'h4 : 4'h1;
            OP_QUAD_ADDR_DATA_WR: n = 4'h4;
            default: n = 4'h1;
        endcase
        return n;
    endfunction

    function automatic logic mode_enters_xip(input logic [7:0] op,
                                             input logic [7:0] mode);
        if (is_ddr(op))
            return mode == MODE_DDR_XIP;
        return mode[7:4] == MODE_XIP_NIBBLE;
    endfunction
endpackage

// ---- hdl/xsw_link_if.sv ----
// Serial link between host controller and memory device
`timescale 1ns/1ps
`default_nettype none
interface xsw_link_if;
    logic cs_n;
    logic sck;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic [3:0] io;

    // Undriven lanes float high through pull-ups
    assign io = (io_out & io_oe) | ~io_oe;

    modport host (output cs_n, output sck, output io_out, output io_oe,
                  input io);
    modport dev (input cs_n, input sck, input io);
endinterface
`default_nettype wire

// ---- hdl/xsw_dev_end.sv ----
// Device end: decodes write commands and continuous mode on the link
`timescale 1ns/1ps
`default_nettype none
module xsw_dev_end (
    xsw_link_if.dev link, // Serial link, device side
    input wire logic sys_clk, // System clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic wr_en_set, // Pulse: set write enable latch
    input wire logic wr_en_clr, // Pulse: clear write enable latch
    output logic [7:0] status_reg_one, // Status byte
    output logic mem_wr, // Pulse: write one byte
    output logic [xsw_pkg::ADDR_W-1:0] mem_addr, // Byte address
    output logic [7:0] mem_data, // Byte to write
    output logic xip_active // Continuous mode armed
);
    import xsw_pkg::*;

    typedef enum logic [2:0] {
        DP_IDLE, DP_OPC, DP_HDR, DP_DAT, DP_SKIP
    } xsw_dphase_t;

    function automatic logic [31:0] shift_in(input logic [31:0] acc,
                                             input logic [3:0] r,
                                             input logic [3:0] f,
                                             input logic [3:0] bpc);
        logic [31:0] res;
        res = acc;
        case (bpc)
            4'h1: res = {acc[30:0], r[0]};
            4'h2: res = {acc[29:0], r[1:0]};
            4'h4: res = {acc[27:0], r};
            default: res = {acc[23:0], r, f};
        endcase
        return res;
    endfunction

    // Frame state, cleared whenever chip select is high
    logic frame_rst_n;
    logic [3:0] rise_reg;
    xsw_dphase_t phase_reg, phase_next, cur;
    logic [7:0] op_reg, op_next, eff_op;
    logic [31:0] acc_reg, acc_next, acc_shift;
    logic [5:0] cnt_reg, cnt_next, cnt_sum;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [3:0] bpc;
    logic hdr_done;
    logic byte_done;

    // Link state that survives frames
    logic xip_reg, xip_next;
    logic [7:0] xip_op_reg, xip_op_next;
    logic tog_reg, tog_next;
    logic [ADDR_W-1:0] hold_addr_reg, hold_addr_next;
    logic [7:0] hold_data_reg, hold_data_next;
    logic wr_en_meta_reg, wr_en_sync_reg;

    // System side
    logic wr_en_reg, wr_en_next;
    logic tog_s1_reg, tog_s2_reg, tog_s3_reg;
    logic xip_s1_reg, xip_s2_reg;
    logic mem_wr_reg, mem_wr_next;
    logic [ADDR_W-1:0] mem_addr_reg, mem_addr_next;
    logic [7:0] mem_data_reg, mem_data_next;

    assign frame_rst_n = nrst & ~link.cs_n;

    // Rising-edge sample; frame logic consumes it on the falling edge
    always_ff @(posedge link.sck or negedge frame_rst_n) begin
        if (!frame_rst_n)
            rise_reg <= 4'h0;
        else
            rise_reg <= link.io;
    end

    always_comb begin
        // Continuous frame reuses the armed command, no opcode
        cur = (phase_reg == DP_IDLE) ?
              (xip_reg ? DP_HDR : DP_OPC) : phase_reg;
        eff_op = (phase_reg == DP_IDLE) ? xip_op_reg : op_reg;
        if (cur == DP_OPC)
            bpc = 4'h1;
        else
            bpc = lanes_of(eff_op, cur == DP_DAT)
                  << is_ddr(eff_op);
        acc_shift = shift_in(acc_reg, rise_reg, link.io, bpc);
        cnt_sum = cnt_reg + {2'h0, bpc};
        phase_next = cur;
        op_next = eff_op;
        acc_next = acc_shift;
        cnt_next = cnt_sum;
        addr_next = addr_reg;
        hdr_done = 1'h0;
        byte_done = 1'h0;
        unique case (cur)
            DP_OPC: begin
                if (cnt_sum == OPC_BITS) begin
                    cnt_next = 6'h00;
                    op_next = acc_shift[7:0];
                    // Unknown opcodes are ignored to end of frame
                    phase_next = is_write_op(acc_shift[7:0]) ?
                                 DP_HDR : DP_SKIP;
                end
            end
            DP_HDR: begin
                if (cnt_sum == HDR_BITS) begin
                    cnt_next = 6'h00;
                    // Upper address bits beyond the array are ignored
                    addr_next = acc_shift[ADDR_W+7:8];
                    hdr_done = 1'h1;
                    phase_next = DP_DAT;
                end
            end
            DP_DAT: begin
                if (cnt_sum == BYTE_BITS) begin
                    cnt_next = 6'h00;
                    byte_done = 1'h1;
                    addr_next = addr_reg + ADDR_W'(1);
                end
            end
            DP_IDLE, DP_SKIP: begin
                acc_next = acc_reg;
                cnt_next = cnt_reg;
            end
        endcase
    end

    always_ff @(negedge link.sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            phase_reg <= DP_IDLE;
            op_reg <= 8'h00;
            acc_reg <= 32'h00000000;
            cnt_reg <= 6'h00;
            addr_reg <= ADDR_RESET;
        end else begin
            phase_reg <= phase_next;
            op_reg <= op_next;
            acc_reg <= acc_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
        end
    end

    always_comb begin
        xip_next = xip_reg;
        xip_op_next = xip_op_reg;
        tog_next = tog_reg;
        hold_addr_next = hold_addr_reg;
        hold_data_next = hold_data_reg;
        if (hdr_done) begin
            // Any non-matching mode byte disarms, inverse included
            xip_next = mode_enters_xip(op_next, acc_shift[7:0]);
            xip_op_next = op_next;
        end
        if (byte_done && wr_en_sync_reg) begin
            tog_next = ~tog_reg;
            hold_addr_next = addr_reg;
            hold_data_next = acc_shift[7:0];
        end
    end

    always_ff @(negedge link.sck or negedge nrst) begin
        if (!nrst) begin
            xip_reg <= 1'h0;
            xip_op_reg <= 8'h00;
            tog_reg <= 1'h0;
            hold_addr_reg <= ADDR_RESET;
            hold_data_reg <= 8'h00;
            wr_en_meta_reg <= 1'h0;
            wr_en_sync_reg <= 1'h0;
        end else begin
            xip_reg <= xip_next;
            xip_op_reg <= xip_op_next;
            tog_reg <= tog_next;
            hold_addr_reg <= hold_addr_next;
            hold_data_reg <= hold_data_next;
            wr_en_meta_reg <= wr_en_reg;
            wr_en_sync_reg <= wr_en_meta_reg;
        end
    end

    // Hold registers stay put at least one link clock per byte,
    // far longer than the three system cycles the toggle needs
    always_comb begin
        mem_wr_next = tog_s2_reg ^ tog_s3_reg;
        mem_addr_next = mem_wr_next ? hold_addr_reg : mem_addr_reg;
        mem_data_next = mem_wr_next ? hold_data_reg : mem_data_reg;
        // Only software clears the latch; a write leaves it alone
        wr_en_next = wr_en_reg;
        if (wr_en_set)
            wr_en_next = 1'h1;
        else if (wr_en_clr)
            wr_en_next = 1'h0;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_en_reg <= 1'h0;
            tog_s1_reg <= 1'h0;
            tog_s2_reg <= 1'h0;
            tog_s3_reg <= 1'h0;
            xip_s1_reg <= 1'h0;
            xip_s2_reg <= 1'h0;
            mem_wr_reg <= 1'h0;
            mem_addr_reg <= ADDR_RESET;
            mem_data_reg <= 8'h00;
        end else begin
            wr_en_reg <= wr_en_next;
            tog_s1_reg <= tog_reg;
            tog_s2_reg <= tog_s1_reg;
            tog_s3_reg <= tog_s2_reg;
            xip_s1_reg <= xip_reg;
            xip_s2_reg <= xip_s1_reg;
            mem_wr_reg <= mem_wr_next;
            mem_addr_reg <= mem_addr_next;
            mem_data_reg <= mem_data_next;
        end
    end

    always_comb begin
        status_reg_one = 8'h00;
        status_reg_one[WR_EN_BIT] = wr_en_reg;
    end
    assign mem_wr = mem_wr_reg;
    assign mem_addr = mem_addr_reg;
    assign mem_data = mem_data_reg;
    assign xip_active = xip_s2_reg;
endmodule
`default_nettype wire

// ---- hdl/xsw_host_end.sv ----
// Host end: sends write frames on the link from a derived clock
`timescale 1ns/1ps
`default_nettype none
module xsw_host_end (
    xsw_link_if.host link, // Serial link, host side
    input wire logic sys_clk, // System clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic start, // Pulse: begin one write frame
    input wire logic [7:0] cmd, // Write opcode
    input wire logic [23:0] addr, // Start address
    input wire logic [7:0] mode, // Mode byte
    input wire logic [8:0] byte_count, // Data bytes, at least one
    input wire logic [7:0] data_in, // Next data byte
    output logic data_take, // Pulse: data_in consumed
    output logic busy, // Frame in progress
    output logic xip_armed // Next frame skips the opcode
);
    import xsw_pkg::*;

    typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_TAIL} xsw_hst_t;
    typedef enum logic [1:0] {SEC_OPC, SEC_HDR, SEC_DAT} xsw_sec_t;

    xsw_hst_t st_reg, st_next;
    xsw_sec_t sec_reg, sec_next;
    logic [7:0] tmr_reg, tmr_next;
    logic sck_reg, sck_next, cs_n_reg, cs_n_next;
    logic [3:0] io_reg, io_next, oe_reg, oe_next, lanes;
    logic [39:0] sh_reg, sh_next;
    logic [5:0] left_reg, left_next, left_sub;
    logic [8:0] nbyte_reg, nbyte_next;
    logic [7:0] op_reg, op_next, mode_reg, mode_next;
    logic pend_reg, pend_next, fin_reg, fin_next, take_reg, take_next;
    logic xip_reg, xip_next;
    logic [7:0] xip_op_reg, xip_op_next;
    logic do_emit;

    always_comb begin
        st_next = st_reg;
        sec_next = sec_reg;
        tmr_next = (tmr_reg == 8'h00) ? SCK_HALF_CYC - 8'h01
                                      : tmr_reg - 8'h01;
        sck_next = sck_reg;
        cs_n_next = cs_n_reg;
        io_next = io_reg;
        oe_next = oe_reg;
        sh_next = sh_reg;
        left_next = left_reg;
        nbyte_next = nbyte_reg;
        op_next = op_reg;
        mode_next = mode_reg;
        pend_next = pend_reg;
        fin_next = fin_reg;
        take_next = 1'h0;
        xip_next = xip_reg;
        xip_op_next = xip_op_reg;
        lanes = (sec_reg == SEC_OPC) ? 4'h1
                : lanes_of(op_reg, sec_reg == SEC_DAT);
        left_sub = left_reg - {2'h0, lanes};
        do_emit = 1'h0;
        unique case (st_reg)
            HS_IDLE: begin
                tmr_next = SCK_HALF_CYC - 8'h01;
                if (start) begin
                    // While armed the opcode is left out entirely
                    op_next = xip_reg ? xip_op_reg : cmd;
                    sec_next = xip_reg ? SEC_HDR : SEC_OPC;
                    left_next = xip_reg ? HDR_BITS : OPC_BITS;
                    sh_next = xip_reg ? {addr, mode, 8'h00}
                                      : {cmd, addr, mode};
                    mode_next = mode;
                    nbyte_next = byte_count;
                    pend_next = 1'h0;
                    fin_next = 1'h0;
                    cs_n_next = 1'h0;
                    st_next = HS_SHIFT;
                end
            end
            HS_SHIFT: begin
                // Mode 0 only: clock idles low, data set mid-half
                if (tmr_reg == 8'h00) begin
                    sck_next = ~sck_reg;
                    if (sck_reg && fin_reg) begin
                        st_next = HS_TAIL;
                    end
                end
                if (tmr_reg == SCK_EMIT_AT)
                    do_emit = !fin_reg && (!sck_reg || pend_reg);
            end
            HS_TAIL: begin
                if (tmr_reg == 8'h00) begin
                    cs_n_next = 1'h1;
                    oe_next = 4'h0;
                    st_next = HS_IDLE;
                end
            end
        endcase
        if (do_emit) begin
            // Lane 3 (or the highest used) carries the first bit
            unique case (lanes)
                4'h1: io_next = {3'h7, sh_reg[39]};
                4'h2: io_next = {2'h3, sh_reg[39:38]};
                default: io_next = sh_reg[39:36];
            endcase
            oe_next = (lanes == 4'h1) ? 4'h1
                      : (lanes == 4'h2) ? 4'h3 : 4'hF;
            sh_next = sh_reg << lanes;
            left_next = left_sub;
            pend_next = !sck_reg && sec_reg != SEC_OPC && is_ddr(op_reg);
            if (left_sub == 6'h00) begin
                unique case (sec_reg)
                    SEC_OPC: begin
                        sec_next = SEC_HDR;
                        left_next = HDR_BITS;
                    end
                    SEC_HDR: begin
                        xip_next = mode_enters_xip(op_reg, mode_reg);
                        xip_op_next = op_reg;
                        sec_next = SEC_DAT;
                        left_next = BYTE_BITS;
                        sh_next = {data_in, 32'h00000000};
                        take_next = 1'h1;
                    end
                    SEC_DAT: begin
                        nbyte_next = nbyte_reg - 9'h001;
                        left_next = BYTE_BITS;
                        if (nbyte_reg <= 9'h001) begin
                            fin_next = 1'h1;
                        end else begin
                            sh_next = {data_in, 32'h00000000};
                            take_next = 1'h1;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= HS_IDLE;
            sec_reg <= SEC_OPC;
            tmr_reg <= 8'h00;
            sck_reg <= 1'h0;
            cs_n_reg <= 1'h1;
            io_reg <= 4'hF;
            oe_reg <= 4'h0;
            sh_reg <= SHIFT_RESET;
            left_reg <= 6'h00;
            nbyte_reg <= 9'h000;
            op_reg <= 8'h00;
            mode_reg <= 8'h00;
            pend_reg <= 1'h0;
            fin_reg <= 1'h0;
            take_reg <= 1'h0;
            xip_reg <= 1'h0;
            xip_op_reg <= 8'h00;
        end else begin
            st_reg <= st_next;
            sec_reg <= sec_next;
            tmr_reg <= tmr_next;
            sck_reg <= sck_next;
            cs_n_reg <= cs_n_next;
            io_reg <= io_next;
            oe_reg <= oe_next;
            sh_reg <= sh_next;
            left_reg <= left_next;
            nbyte_reg <= nbyte_next;
            op_reg <= op_next;
            mode_reg <= mode_next;
            pend_reg <= pend_next;
            fin_reg <= fin_next;
            take_reg <= take_next;
            xip_reg <= xip_next;
            xip_op_reg <= xip_op_next;
        end
    end

    assign link.cs_n = cs_n_reg;
    assign link.sck = sck_reg;
    assign link.io_out = io_reg;
    assign link.io_oe = oe_reg;
    assign data_take = take_reg;
    assign busy = st_reg != HS_IDLE;
    assign xip_armed = xip_reg;
endmodule
`default_nettype wire

// ---- test/xsw_link_chk.sv ----
// Wire-level checks on the link between host end and device end
`timescale 1ns/1ps
`default_nettype none
module xsw_link_chk (
    input wire logic sys_clk, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic cs_n, // Chip select, low active
    input wire logic sck, // Link clock
    input wire logic [3:0] io_out, // Host lane values
    input wire logic [3:0] io_oe, // Host lane enables
    input wire logic [3:0] io // Resolved lanes
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("link clock active while deselected");
    a_oe_idle: assert property (cs_n |-> io_oe == 4'h0)
        else $error("lanes driven while deselected");
    a_cs_setup: assert property ($fell(cs_n) |-> !sck [*8] ##1 sck)
        else $error("first clock edge not 8 cycles after select");
    a_cs_hold: assert property
        ($rose(cs_n) |-> !$past(sck, 1) && !$past(sck, 7))
        else $error("deselect too soon after last clock edge");
    a_sck_half: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
        else $error("link clock high phase not 8 cycles");
    a_io_steady: assert property
        (!cs_n && ($rose(sck) || $fell(sck)) |-> $stable(io))
        else $error("lanes change on a link clock edge");
    a_lane_zero: assert property
        (!cs_n && $rose(sck) |-> io_oe[0] && io[0] == io_out[0])
        else $error("lane 0 not driven at rising edge");
    a_oe_width: assert property
        (io_oe inside {4'h0, 4'h1, 4'h3, 4'hF})
        else $error("illegal lane enable pattern");
endmodule
`default_nettype wire

// ---- test/tb_xip_serial_memory_write.sv ----
// Bench joining host end and device end across the link
`timescale 1ns/1ps
`default_nettype none
module tb_xip_serial_memory_write;
    import xsw_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic start = 1'b0;
    logic wr_en_set = 1'b0;
    logic wr_en_clr = 1'b0;
    logic wr_en_on = 1'b0;
    logic [7:0] cmd = 8'h00, mode = 8'h00, data_in = 8'h00, m;
    logic [23:0] addr = 24'h000000;
    logic [8:0] byte_count = 9'h001;
    logic data_take, busy, xip_armed, mem_wr, xip_active;
    logic [7:0] status_reg_one, mem_data;
    logic [ADDR_W-1:0] mem_addr;
    logic [7:0] buf_q[$];
    logic [25:0] exp_q[$];
    logic [7:0] ops[6] = '{OP_FAST_WR, OP_DDR_FAST_WR, OP_DUAL_DATA_WR,
        OP_DUAL_ADDR_DATA_WR, OP_QUAD_DATA_WR, OP_QUAD_ADDR_DATA_WR};
    int failures = 0, checked = 0, idx = 0;

    always #2 sys_clk = ~sys_clk;

    xsw_link_if link();
    xsw_host_end xsw_host_end_inst (.link(link), .sys_clk(sys_clk),
        .nrst(nrst), .start(start), .cmd(cmd), .addr(addr), .mode(mode),
        .byte_count(byte_count), .data_in(data_in), .data_take(data_take),
        .busy(busy), .xip_armed(xip_armed));
    xsw_dev_end xsw_dev_end_inst (.link(link), .sys_clk(sys_clk),
        .nrst(nrst), .wr_en_set(wr_en_set), .wr_en_clr(wr_en_clr),
        .status_reg_one(status_reg_one), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_data(mem_data), .xip_active(xip_active));
    xsw_link_chk xsw_link_chk_inst (.sys_clk(sys_clk), .nrst(nrst),
        .cs_n(link.cs_n), .sck(link.sck), .io_out(link.io_out),
        .io_oe(link.io_oe), .io(link.io));

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] expv);
        checked++;
        if (seen !== expv) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, expv, seen);
        end
    endtask

    // Byte i of a burst lands at the start address plus i, wrapping
    function automatic logic [25:0] exp_write(input logic [23:0] a,
                                              input int i,
                                              input logic [7:0] d);
        return {a[ADDR_W-1:0] + ADDR_W'(i), d};
    endfunction

    task automatic close_out();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Next byte presented the cycle after each take
    always @(posedge sys_clk) begin
        if (data_take === 1'b1) begin
            idx = idx + 1;
            if (idx < buf_q.size()) data_in <= buf_q[idx];
        end
    end

    always @(posedge sys_clk) begin
        if (mem_wr === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected write", 1, 0);
            else
                check("write", {mem_addr, mem_data},
                      exp_q.pop_front());
        end
    end

    // One frame; n random bytes, xe is the expected continuous state
    task automatic frame(input logic [7:0] c, input logic [23:0] a,
                         input logic [7:0] md, input int n, input logic xe);
        int i;
        buf_q.delete();
        for (i = 0; i < n; i++) begin
            buf_q.push_back(8'($urandom));
            if (wr_en_on) exp_q.push_back(exp_write(a, i, buf_q[i]));
        end
        idx = 0;
        cmd <= c;
        addr <= a;
        mode <= md;
        byte_count <= 9'(n);
        data_in <= buf_q[0];
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        i = 0;
        do begin
            @(posedge sys_clk);
            #1;
            i++;
        end while (busy !== 1'b0 && i < 5000);
        if (i >= 5000) check("busy stuck", 1, 0);
        repeat (12) @(posedge sys_clk);
        check("writes missing", exp_q.size(), 0);
        check("device continuous", xip_active, xe);
        check("host continuous", xip_armed, xe);
    endtask

    task automatic latch(input logic on);
        wr_en_set <= on;
        wr_en_clr <= !on;
        @(posedge sys_clk);
        wr_en_set <= 1'b0;
        wr_en_clr <= 1'b0;
        wr_en_on = on;
        repeat (2) @(posedge sys_clk);
        check("status", status_reg_one, {6'h00, on, 1'b0});
    endtask

    initial begin
        // More than three times the longest full run of frames
        #250000;
        failures++;
        close_out();
    end

    initial begin
        void'($urandom(17));
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        check("status reset", status_reg_one, 8'h00);
        frame(OP_FAST_WR, 24'($urandom), 8'h00, 2, 1'b0);
        latch(1'b1);
        foreach (ops[k]) begin
            m = 8'($urandom);
            if (m[7:4] == 4'hA) m[7] = 1'b0;
            frame(ops[k], 24'($urandom), m, 1 + $urandom % 4, 1'b0);
            m = ops[k] == OP_DDR_FAST_WR ? MODE_DDR_XIP : {4'hA, 4'($urandom)};
            frame(ops[k], 24'($urandom), m, 2, 1'b1);
            frame(8'h00, 24'($urandom), m, 3, 1'b1);
            frame(8'h00, 24'($urandom), ~m, 1, 1'b0);
        end
        frame(OP_DDR_FAST_WR, 24'($urandom), 8'hA7, 2, 1'b0);
        frame(OP_QUAD_ADDR_DATA_WR, 24'hC3FFFF, 8'h00, 3, 1'b0);
        frame(OP_DUAL_DATA_WR, 24'h03FFFE, 8'h00, 4, 1'b0);
        // Opcode outside the write set: whole frame ignored
        wr_en_on = 1'b0;
        frame(8'h5C, 24'($urandom), 8'h00, 2, 1'b0);
        wr_en_on = 1'b1;
        check("latch kept", status_reg_one, 8'h02);
        latch(1'b0);
        frame(OP_QUAD_DATA_WR, 24'($urandom), 8'h00, 3, 1'b0);
        close_out();
    end
endmodule
`default_nettype wire
